// [verilog/epo_pkg.sv]
// Purpose: constants and types of the energy pulse output generator
// Assumes: 100 MHz system clock, 16-bit signed filtered power word
// Notes:   register offsets are byte addresses on a 32-bit Avalon-MM slave
package epo_pkg;

    // clocks
    localparam int unsigned CLK_HZ        = 100_000_000;
    localparam int unsigned OSC_HZ        = 450_000;

    // power path widths
    localparam int          PW_W          = 16;
    localparam int          ACC_W         = 40;
    localparam int          CNT_W         = 28;
    localparam int          PRE_W         = 11;

    // full-scale magnitude of the power word accumulates to 0.204 x base rate
    localparam int unsigned FULL_SCALE    = 32768;
    localparam int unsigned FULL_RATE_MIL = 204;
    // base threshold for code 00: 2^15 * 2^19 / 0.204
    localparam logic [39:0] LOW_THR_BASE  = 40'h139b8fd59c;
    // smallest rate that still produces pulses, in parts per million of base
    localparam int unsigned NOLOAD_PPM    = 14;

    // total shift of the calibration threshold (rate code + multiplier)
    localparam logic [3:0]  CF_SHIFT_SCF1 = 4'h7;
    localparam logic [3:0]  CF_SHIFT_SCF0 = 4'h6;
    localparam logic [3:0]  CF_SHIFT_HF   = 4'he;

    // pulse timing in printed units
    localparam int unsigned CF_WIDTH_MS   = 173;
    localparam int unsigned CF_HALF_MS    = 346;
    localparam int unsigned LOW_HALF_MS   = 1062;
    localparam int unsigned LOW_WIDTH_MS  = 500;
    localparam int unsigned HF_WIDTH_US   = 35;
    localparam int unsigned HF_WIDTH_CYC  = HF_WIDTH_US * (CLK_HZ / 1_000_000);

    // register map
    localparam int          ADDR_W        = 4;
    localparam logic [3:0]  REG_CTRL      = 4'h0;
    localparam logic [3:0]  REG_STATUS    = 4'h4;
    localparam logic [3:0]  REG_MASK      = 4'h8;
    localparam logic [3:0]  REG_STATE     = 4'hc;

    // status bit positions
    localparam int          EVT_W         = 3;
    localparam int          ST_CF         = 0;
    localparam int          ST_LOW        = 1;
    localparam int          ST_REV        = 2;

    typedef struct packed {
        logic calib_scale_sel;
        logic rate_hi;
        logic rate_lo;
        logic en;
    } epo_ctrl_t;

    localparam epo_ctrl_t   CTRL_RST      = 4'h1;

    typedef struct packed {
        epo_ctrl_t              ctrl;
        logic [EVT_W-1:0]       sts;
        logic [EVT_W-1:0]       mask;
        logic                   ack;
        logic [31:0]            rdata;
        logic [31:0]            tick_acc;
        logic [ACC_W-1:0]       acc;
        logic [PRE_W-1:0]       pre;
        logic [CNT_W-1:0]       cf_per;
        logic [CNT_W-1:0]       cf_cnt;
        logic [CNT_W-1:0]       low_per;
        logic [CNT_W-1:0]       low_cnt;
        logic                   side_b;
        logic                   cf_out;
        logic                   low_a_n;
        logic                   low_b_n;
        logic                   rev;
    } epo_state_t;

endpackage : epo_pkg

// [verilog/epo_pulse_gen.sv]
// Purpose: energy to pulse-rate converter with low-rate and calibration outputs
// Assumes: power_word comes from logic on sys_clk; rates scale with osc_hz
// Notes:   registers on Avalon-MM, one wait state per access
`timescale 1ns/1ns
module epo_pulse_gen #(
    parameter int unsigned OSC_FREQ_HZ   = epo_pkg::OSC_HZ,
    parameter int unsigned CF_WIDTH_CYC  = epo_pkg::CF_WIDTH_MS * (epo_pkg::CLK_HZ / 1000),
    parameter int unsigned CF_HALF_CYC   = epo_pkg::CF_HALF_MS * (epo_pkg::CLK_HZ / 1000),
    parameter int unsigned LOW_HALF_CYC  = epo_pkg::LOW_HALF_MS * (epo_pkg::CLK_HZ / 1000),
    parameter int unsigned LOW_WIDTH_CYC = epo_pkg::LOW_WIDTH_MS * (epo_pkg::CLK_HZ / 1000)
)
(
    // clock and reset
    input  wire logic                          sys_clk,
    input  wire logic                          rst_n,
    // filtered power
    input  wire logic signed [epo_pkg::PW_W-1:0] power_word,
    // avalon-mm slave
    input  wire logic [epo_pkg::ADDR_W-1:0]    avs_address,
    input  wire logic                          avs_read,
    input  wire logic                          avs_write,
    input  wire logic [31:0]                   avs_writedata,
    input  wire logic [3:0]                    avs_byteenable,
    output logic [31:0]                        avs_readdata,
    output logic                               avs_waitrequest,
    // pulse outputs
    output logic                               low_rate_pulse_a,
    output logic                               low_rate_pulse_b,
    output logic                               calib_pulse_out,
    output logic                               reverse_power_flag,
    // interrupt
    output logic                               irq
);

    localparam epo_pkg::epo_state_t ST_RST = '{
        ctrl:    epo_pkg::CTRL_RST,
        // side starts on b so that the first low-rate quantum lands on output a
        side_b:  1'b1,
        low_a_n: 1'b1,
        low_b_n: 1'b1,
        default: '0
    };

    epo_pkg::epo_state_t              s_q;
    epo_pkg::epo_state_t              s_d;
    logic                             hf;
    logic [1:0]                       sel;
    logic [3:0]                       cf_shift;
    logic [3:0]                       mult_log;
    logic [epo_pkg::ACC_W-1:0]        cf_thr;
    logic [epo_pkg::PW_W:0]           mag;
    logic                             noload;
    logic [32:0]                      tick_sum;
    logic                             tick;
    logic [epo_pkg::ACC_W-1:0]        sum;
    logic                             cf_evt;
    logic                             low_evt;
    logic [epo_pkg::PRE_W-1:0]        pre_top;
    logic [epo_pkg::CNT_W-1:0]        width;

    localparam int PRE_W = epo_pkg::PRE_W;
    typedef logic [PRE_W-1:0] PRE_W_T;

    always_comb
    begin
        s_d      = s_q;
        hf       = !s_q.ctrl.calib_scale_sel && s_q.ctrl.rate_hi && s_q.ctrl.rate_lo;
        sel      = {s_q.ctrl.rate_hi, s_q.ctrl.rate_lo};
        cf_shift = epo_pkg::CF_SHIFT_SCF0;
        cf_evt   = 1'b0;
        low_evt  = 1'b0;
        width    = '0;

        // bus: capture read data on the first cycle, commit writes on the answer cycle
        s_d.ack = (avs_read || avs_write) && !s_q.ack;
        if (avs_read && !s_q.ack)
        begin
            case (avs_address)
                epo_pkg::REG_CTRL:   s_d.rdata = {28'h0000000, s_q.ctrl};
                epo_pkg::REG_STATUS: s_d.rdata = {29'h00000000, s_q.sts};
                epo_pkg::REG_MASK:   s_d.rdata = {29'h00000000, s_q.mask};
                epo_pkg::REG_STATE:  s_d.rdata = {27'h0000000, hf, s_q.cf_out,
                                                  s_q.low_b_n, s_q.low_a_n, s_q.rev};
                default:             s_d.rdata = 32'h00000000;
            endcase
        end
        if (avs_write && s_q.ack && avs_byteenable[0])
        begin
            case (avs_address)
                epo_pkg::REG_CTRL:   s_d.ctrl = avs_writedata[3:0];
                epo_pkg::REG_STATUS: s_d.sts  = s_q.sts & ~avs_writedata[epo_pkg::EVT_W-1:0];
                epo_pkg::REG_MASK:   s_d.mask = avs_writedata[epo_pkg::EVT_W-1:0];
                default:             s_d.mask = s_q.mask;
            endcase
        end

        // oscillator tick from a fractional accumulator, so rates follow osc_hz
        tick_sum = {1'b0, s_q.tick_acc} + 33'(OSC_FREQ_HZ);
        tick     = tick_sum >= 33'(epo_pkg::CLK_HZ);
        if (tick)
        begin
            s_d.tick_acc = 32'(tick_sum - 33'(epo_pkg::CLK_HZ));
        end
        else
        begin
            s_d.tick_acc = tick_sum[31:0];
        end

        // calibration threshold: base threshold shifted by rate code and multiplier
        if (s_q.ctrl.calib_scale_sel)
        begin
            cf_shift = epo_pkg::CF_SHIFT_SCF1;
        end
        else if (hf)
        begin
            cf_shift = epo_pkg::CF_SHIFT_HF;
        end
        cf_thr   = epo_pkg::LOW_THR_BASE >> cf_shift;
        mult_log = cf_shift - {2'b00, sel};
        pre_top  = PRE_W_T'((12'h001 << mult_log) - 12'h001);

        // magnitude of the power word and the creep threshold
        mag    = power_word[epo_pkg::PW_W-1] ? -{power_word[epo_pkg::PW_W-1], power_word}
                                             : {1'b0, power_word};
        noload = 64'(mag) * 64'(epo_pkg::FULL_RATE_MIL) * 64'd1000
                 < 64'(epo_pkg::FULL_SCALE) * 64'(epo_pkg::NOLOAD_PPM);

        // energy accumulates at oscillator rate; one calibration quantum per threshold
        sum = s_q.acc + epo_pkg::ACC_W'(mag);
        if (tick && s_q.ctrl.en && !noload)
        begin
            if (sum >= cf_thr)
            begin
                s_d.acc = sum - cf_thr;
                cf_evt  = 1'b1;
            end
            else
            begin
                s_d.acc = sum;
            end
        end

        // period counters saturate at their half-width limits
        if (s_q.cf_per != epo_pkg::CNT_W'(CF_HALF_CYC))
        begin
            s_d.cf_per = s_q.cf_per + 1'b1;
        end
        if (s_q.low_per != epo_pkg::CNT_W'(LOW_HALF_CYC))
        begin
            s_d.low_per = s_q.low_per + 1'b1;
        end
        if (s_q.cf_cnt != '0)
        begin
            s_d.cf_cnt = s_q.cf_cnt - 1'b1;
        end
        if (s_q.low_cnt != '0)
        begin
            s_d.low_cnt = s_q.low_cnt - 1'b1;
        end

        if (cf_evt)
        begin
            if (hf)
            begin
                width = epo_pkg::CNT_W'(epo_pkg::HF_WIDTH_CYC);
            end
            else if (s_q.cf_per < epo_pkg::CNT_W'(CF_HALF_CYC))
            begin
                width = s_q.cf_per >> 1;
            end
            else
            begin
                width = epo_pkg::CNT_W'(CF_WIDTH_CYC);
            end
            // a period of one cycle would halve to nothing; keep the pulse visible
            s_d.cf_cnt = (width == '0) ? epo_pkg::CNT_W'(1) : width;
            s_d.cf_per = '0;
            s_d.rev    = power_word[epo_pkg::PW_W-1];
            s_d.sts[epo_pkg::ST_CF] = 1'b1;
            if (s_d.rev != s_q.rev)
            begin
                s_d.sts[epo_pkg::ST_REV] = 1'b1;
            end
            // the low-rate quantum is a whole number of calibration quanta
            if (s_q.pre >= pre_top)
            begin
                s_d.pre = '0;
                low_evt = 1'b1;
            end
            else
            begin
                s_d.pre = s_q.pre + 1'b1;
            end
        end

        if (low_evt)
        begin
            if (s_q.low_per < epo_pkg::CNT_W'(LOW_HALF_CYC))
            begin
                width = s_q.low_per >> 1;
            end
            else
            begin
                width = epo_pkg::CNT_W'(LOW_WIDTH_CYC);
            end
            s_d.low_cnt = (width == '0) ? epo_pkg::CNT_W'(1) : width;
            s_d.low_per = '0;
            s_d.side_b  = !s_q.side_b;
            s_d.sts[epo_pkg::ST_LOW] = 1'b1;
        end

        // registered pin levels; low outputs idle high
        s_d.cf_out  = s_d.cf_cnt != '0;
        s_d.low_a_n = !((s_d.low_cnt != '0) && !s_d.side_b);
        s_d.low_b_n = !((s_d.low_cnt != '0) && s_d.side_b);
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_q <= ST_RST;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign avs_readdata       = s_q.rdata;
    assign avs_waitrequest    = (avs_read || avs_write) && !s_q.ack;
    assign low_rate_pulse_a   = s_q.low_a_n;
    assign low_rate_pulse_b   = s_q.low_b_n;
    assign calib_pulse_out    = s_q.cf_out;
    assign reverse_power_flag = s_q.rev;
    assign irq                = |(s_q.sts & s_q.mask);

    // checks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_bus_req;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence

    sequence s_cf_start;
        $rose(calib_pulse_out);
    endsequence

    sequence s_low_start;
        $fell(low_rate_pulse_a) || $fell(low_rate_pulse_b);
    endsequence

    a_bus_answer: assert property (s_bus_req |=> !avs_waitrequest)
        else $error("bus request not answered in one wait state");

    a_low_never_both: assert property (low_rate_pulse_a || low_rate_pulse_b)
        else $error("both low-rate outputs active together");

    a_low_turns: assert property ($fell(low_rate_pulse_a) |-> $past(s_q.side_b))
        else $error("low-rate pulse on a did not follow b");

    a_rev_on_cf: assert property ($changed(reverse_power_flag) |-> $rose(calib_pulse_out)
        || (calib_pulse_out && $past(s_q.cf_cnt) == 1 && s_q.cf_cnt != 0))
        else $error("reverse flag changed without a calibration pulse");

    a_rev_sign: assert property (s_cf_start |-> reverse_power_flag
        == $past(power_word[epo_pkg::PW_W-1]))
        else $error("reverse flag does not match power sign");

    a_hf_width: assert property (s_cf_start ##0 hf |->
        s_q.cf_cnt == epo_pkg::CNT_W'(epo_pkg::HF_WIDTH_CYC))
        else $error("high-frequency calibration width wrong");

    a_noload_hold: assert property (noload && !cf_evt |=> s_q.acc == $past(s_q.acc))
        else $error("accumulator moved below the no-load threshold");

    a_cf_status: assert property (s_cf_start |-> s_q.sts[epo_pkg::ST_CF])
        else $error("calibration event not recorded");

    a_low_from_cf: assert property ($fell(low_rate_pulse_a) || $fell(low_rate_pulse_b)
        |-> $rose(calib_pulse_out) || s_q.cf_per == 0)
        else $error("low-rate pulse without a calibration quantum");

    a_low_width_cap: assert property ($fell(low_rate_pulse_a) |->
        s_q.low_cnt <= epo_pkg::CNT_W'(LOW_WIDTH_CYC) || s_q.low_cnt <= s_q.low_per)
        else $error("low-rate pulse width exceeds its limit");

    // a slow calibration rate outside high-frequency mode keeps the fixed width
    a_cf_width_fixed: assert property (s_cf_start ##0 (!hf
        && $past(s_q.cf_per) >= epo_pkg::CNT_W'(CF_HALF_CYC))
        |-> s_q.cf_cnt == epo_pkg::CNT_W'(CF_WIDTH_CYC))
        else $error("calibration pulse width not the fixed width");

    // a fast calibration rate outside high-frequency mode halves the measured period
    a_cf_width_half: assert property (s_cf_start ##0 (!hf
        && $past(s_q.cf_per) < epo_pkg::CNT_W'(CF_HALF_CYC) && $past(s_q.cf_per) > 1)
        |-> s_q.cf_cnt == ($past(s_q.cf_per) >> 1))
        else $error("calibration pulse width not half the period");

    // a fast low-rate interval halves the measured interval
    a_low_width_half: assert property (s_low_start ##0
        ($past(s_q.low_per) < epo_pkg::CNT_W'(LOW_HALF_CYC) && $past(s_q.low_per) > 1)
        |-> s_q.low_cnt == ($past(s_q.low_per) >> 1))
        else $error("low-rate pulse width not half the interval");

    // below the creep threshold an idle calibration output stays idle
    a_noload_quiet: assert property (noload && s_q.cf_cnt == 0
        |=> !calib_pulse_out)
        else $error("calibration pulse issued below the no-load threshold");

    // a disabled block starts no calibration pulse
    a_off_quiet: assert property (!s_q.ctrl.en && s_q.cf_cnt == 0
        |=> !calib_pulse_out)
        else $error("calibration pulse issued while disabled");

endmodule : epo_pulse_gen

// [tb/epo_meter_model.sv]
// Purpose: pulse counter standing at the far side of the pulse outputs
// Assumes: outputs are sampled on the system clock
// Notes:   measures calibration period and width, watches flag timing
`timescale 1ns/1ns
module epo_meter_model
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // watched outputs
    input  wire logic low_a_n,
    input  wire logic low_b_n,
    input  wire logic calib,
    input  wire logic rev,
    // measurements
    output int        cal_cnt,
    output int        low_cnt,
    output int        cal_per,
    output int        cal_wid,
    output int        rev_bad,
    output int        alt_bad
);
    logic cal_q;
    logic rev_q;
    logic a_q;
    logic b_q;
    logic last_b;
    int   since;
    int   hi;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            {cal_q, rev_q, a_q, b_q, last_b} <= 5'b00111;
            cal_cnt <= 0;
            low_cnt <= 0;
            cal_per <= 0;
            cal_wid <= 0;
            rev_bad <= 0;
            alt_bad <= 0;
            since   <= 0;
            hi      <= 0;
        end
        else
        begin
            cal_q <= calib;
            rev_q <= rev;
            a_q   <= low_a_n;
            b_q   <= low_b_n;
            since <= (calib && !cal_q) ? 1 : since + 1;
            hi    <= calib ? hi + 1 : 0;
            if (calib && !cal_q)
            begin
                cal_cnt <= cal_cnt + 1;
                cal_per <= since;
            end
            if (!calib && cal_q)
                cal_wid <= hi;
            // the flag may only move when a calibration pulse rises
            if (rev !== rev_q && !(calib && !cal_q))
                rev_bad <= rev_bad + 1;
            if ((a_q && !low_a_n) || (b_q && !low_b_n))
            begin
                low_cnt <= low_cnt + 1;
                last_b  <= !low_b_n;
                if ((!low_b_n) == last_b)
                    alt_bad <= alt_bad + 1;
            end
        end
    end
endmodule : epo_meter_model

// [tb/tb_top.sv]
// Purpose: self-checking bench of the energy pulse output generator
// Assumes: oscillator parameter raised to the clock rate to keep the run short
// Notes:   low-rate periods exceed the run, so only their idle level is seen
`timescale 1ns/1ns
module tb_top;
    localparam int unsigned TICK_HZ = 100_000_000;
    localparam int unsigned CAL_W   = 4000;
    localparam int unsigned CAL_H   = 8000;
    typedef struct {
        logic [31:0] ctrl;
        int          pw;
        logic        rev;
    } epo_row_t;

    logic               sys_clk = 1'b0;
    logic               rst_n;
    logic signed [15:0] power_word;
    logic [3:0]         avs_address;
    logic               avs_read;
    logic               avs_write;
    logic [31:0]        avs_writedata;
    logic [3:0]         avs_byteenable;
    logic [31:0]        avs_readdata;
    logic               avs_waitrequest;
    logic               low_rate_pulse_a;
    logic               low_rate_pulse_b;
    logic               calib_pulse_out;
    logic               reverse_power_flag;
    logic               irq;
    int                 error_cnt = 0;
    int                 n_checks = 0;
    int                 cal_cnt, low_cnt, cal_per, cal_wid, rev_bad, alt_bad, snap;
    logic [31:0]        rd;
    real                pe;
    epo_row_t           rows [3];

    always #5 sys_clk = ~sys_clk;

    epo_pulse_gen #(.OSC_FREQ_HZ(TICK_HZ), .CF_WIDTH_CYC(CAL_W), .CF_HALF_CYC(CAL_H),
                    .LOW_HALF_CYC(400), .LOW_WIDTH_CYC(100)) u_epo_pulse_gen (
        .sys_clk(sys_clk), .rst_n(rst_n), .power_word(power_word),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .low_rate_pulse_a(low_rate_pulse_a), .low_rate_pulse_b(low_rate_pulse_b),
        .calib_pulse_out(calib_pulse_out), .reverse_power_flag(reverse_power_flag),
        .irq(irq));

    epo_meter_model u_epo_meter_model (
        .clk(sys_clk), .rst_n(rst_n), .low_a_n(low_rate_pulse_a),
        .low_b_n(low_rate_pulse_b), .calib(calib_pulse_out), .rev(reverse_power_flag),
        .cal_cnt(cal_cnt), .low_cnt(low_cnt), .cal_per(cal_per), .cal_wid(cal_wid),
        .rev_bad(rev_bad), .alt_bad(alt_bad));

    task automatic final_report;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : final_report

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic chk_rng(input string nm, input int e, input int g, input int tol);
        n_checks++;
        if (g < e - tol || g > e + tol)
        begin
            error_cnt++;
            $display("wrong value %s expected %0d seen %0d", nm, e, g);
        end
    endtask : chk_rng

    // holds the request until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                       output logic [31:0] r);
        int n;
        n = 0;
        @(posedge sys_clk);
        avs_address   <= a;
        avs_write     <= wr;
        avs_read      <= !wr;
        avs_writedata <= wd;
        // waitrequest and read data are taken at the same rising edge
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 100);
        if (n >= 100)
            error_cnt++;
        r = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task automatic wait_cal(input int n);
        int target;
        int k;
        target = cal_cnt + n;
        k = 0;
        while (cal_cnt < target && k < 60000)
        begin
            @(posedge sys_clk);
            k++;
        end
        if (k >= 60000)
            error_cnt++;
    endtask : wait_cal

    // period in clock cycles from base divisor, multiplier and full scale
    function automatic real exp_per(input logic [31:0] c, input int p);
        int  k;
        real m;
        k = int'({c[2], c[1]});
        if (c[3])
            m = real'(128 >> k);
        else
            m = (k == 3) ? 2048.0 : real'(64 >> k);
        return 2.0 ** (19 - k) * 32768.0 / (0.204 * m * ((p < 0) ? -p : p)) * 1.0e8 / TICK_HZ;
    endfunction : exp_per

    initial
    begin
        // the scenarios need about 80k cycles
        repeat (95000) @(posedge sys_clk);
        error_cnt++;
        final_report();
    end

    initial
    begin
        rows[0] = '{32'h7, 1000, 1'b0};
        rows[1] = '{32'h7, -1000, 1'b1};
        rows[2] = '{32'hf, 32767, 1'b0};
        {power_word, avs_address, avs_read, avs_write, avs_writedata} = '0;
        avs_byteenable = 4'hf;
        rst_n = 1'b0;
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        chk("low_a", 32'h1, low_rate_pulse_a);
        chk("low_b", 32'h1, low_rate_pulse_b);
        chk("calib", 32'h0, calib_pulse_out);
        bus(1'b0, epo_pkg::REG_CTRL, 32'h0, rd);
        chk("ctrl", {28'h0, epo_pkg::CTRL_RST}, rd);
        bus(1'b0, epo_pkg::REG_MASK, 32'h0, rd);
        chk("mask", 32'h0, rd);
        foreach (rows[i])
        begin
            power_word <= rows[i].pw[15:0];
            bus(1'b1, epo_pkg::REG_CTRL, rows[i].ctrl, rd);
            wait_cal(2);
            pe = exp_per(rows[i].ctrl, rows[i].pw);
            chk_rng("cal_period", int'(pe), cal_per, int'(pe) / 100 + 2);
            chk_rng("cal_width", (rows[i].ctrl[3:1] == 3'b011) ? epo_pkg::HF_WIDTH_CYC
                    : ((pe < CAL_H) ? int'(pe) / 2 : CAL_W), cal_wid, 1);
            chk("reverse", {31'h0, rows[i].rev}, {31'h0, reverse_power_flag});
        end
        power_word <= 16'sh0002;
        bus(1'b1, epo_pkg::REG_CTRL, 32'h7, rd);
        repeat (6000) @(posedge sys_clk);
        snap = cal_cnt;
        repeat (12000) @(posedge sys_clk);
        chk_rng("cal_noload", snap, cal_cnt, 0);
        bus(1'b1, epo_pkg::REG_CTRL, 32'h6, rd);
        bus(1'b0, epo_pkg::REG_STATUS, 32'h0, rd);
        chk("status", 32'h5, rd);
        chk("irq_masked", 32'h0, irq);
        bus(1'b1, epo_pkg::REG_MASK, 32'h1, rd);
        repeat (2) @(negedge sys_clk);
        chk("irq_set", 32'h1, irq);
        bus(1'b1, epo_pkg::REG_STATUS, 32'h7, rd);
        repeat (2) @(negedge sys_clk);
        chk("irq_clear", 32'h0, irq);
        bus(1'b0, epo_pkg::REG_STATUS, 32'h0, rd);
        chk("status_clr", 32'h0, rd);
        chk_rng("rev_moves", 0, rev_bad, 0);
        chk_rng("alternation", 0, alt_bad, 0);
        final_report();
    end
endmodule : tb_top
